// >>> core/mct_pkg.sv
// Summary of operation
// - Cleared cpu_updating lets tx_request launch frame.
// - Remote frame during update sets request, pending.
// - Receive object tx_request sends remote frame.
// - Stored data frame sets new_data_flag.
// - Overwrite of unread frame sets message_lost_flag.
// - Loop-back drives recessive level on transmit pins.
// - Loop-back ANDs internal transmits into both receives.
// - Loop-back ignores external receive pins.
// - Loop-back only when both select bits set.
// - Single-try clears tx_request when frame starts.
// - Only valid objects may transmit.
// - Thirty-two objects shared, node chosen per object.
package mct_pkg;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_OBJ = 32;
    localparam int OBJ_IDX_W = 5;
    localparam int ADDR_W = 10;
    localparam int NUM_NODES = 2;
    localparam int SYNC_STAGES = 2;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_DATA_LOW = 4'h4;
    localparam logic [3:0] OFF_DATA_HIGH = 4'h8;
    localparam logic [3:0] OFF_CFG = 4'hc;
    localparam logic [9:0] OFF_BTR_A = 10'h200;
    localparam logic [9:0] OFF_BTR_B = 10'h204;
    localparam logic [9:0] OFF_STATUS = 10'h208;

    // ****************************************
    // Field positions and codes
    // ****************************************
    localparam int CTL_IRQ = 0;
    localparam int CTL_VALID = 2;
    localparam int CTL_RMT = 4;
    localparam int CTL_TX_REQUEST = 6;
    localparam int CTL_NEWD = 8;
    localparam int CTL_UPD = 10;
    localparam int CTL_LOST = 12;
    localparam logic [1:0] CODE_SET = 2'h2;
    localparam logic [1:0] CODE_CLR = 2'h1;
    localparam int CFG_NODE = 0;
    localparam int CFG_DIR_TX = 1;
    localparam int CFG_STT = 2;
    localparam int BTR_LBM = 0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    typedef enum logic [0:0] {
        MCT_WR_COLLECT = 1'b0,
        MCT_WR_RESP = 1'b1
    } mct_wr_state_t;
endpackage

// >>> core/mct_arb_if.sv
`timescale 1ns/1ps
// Ready objects of one node and the object chosen for it
interface mct_arb_if;
    logic [mct_pkg::NUM_OBJ-1:0] pending;
    logic grant_valid;
    logic [mct_pkg::OBJ_IDX_W-1:0] grant_idx;
    modport arb (
        input pending,
        output grant_valid,
        output grant_idx
    );
    modport user (
        output pending,
        input grant_valid,
        input grant_idx
    );
endinterface

// >>> core/mct_tx_arbiter.sv
`timescale 1ns/1ps
module mct_tx_arbiter (
    input wire logic aclk,
    input wire logic aresetn,
    mct_arb_if.arb arb
);
    // Lowest index wins; registered to keep the path short
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arb.grant_valid <= 1'b0;
            arb.grant_idx <= '0;
        end else begin
            arb.grant_valid <= |arb.pending;
            arb.grant_idx <= '0;
            for (int i = mct_pkg::NUM_OBJ - 1; i >= 0; i--) begin
                if (arb.pending[i]) begin
                    arb.grant_idx <= i[mct_pkg::OBJ_IDX_W-1:0];
                end
            end
        end
    end
endmodule

// >>> core/mct_loopback.sv
`timescale 1ns/1ps
module mct_loopback (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic lbm_active,
    input wire logic [1:0] can_rx_pin,
    input wire logic [1:0] node_int_tx,
    output logic [1:0] can_tx_pin,
    output logic [1:0] node_int_rx
);
    logic [1:0] rx_meta_reg;
    logic [1:0] rx_sync_reg;

    // Pins are asynchronous: two stages before use
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_meta_reg <= 2'h3;
            rx_sync_reg <= 2'h3;
        end else begin
            rx_meta_reg <= can_rx_pin;
            rx_sync_reg <= rx_meta_reg;
        end
    end

    // Wired-AND bus in loop-back only: dominant zero from either node wins; otherwise each node uses its own pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            can_tx_pin <= 2'h3;
            node_int_rx <= 2'h3;
        end else if (lbm_active) begin
            can_tx_pin <= 2'h3;
            node_int_rx <= {2{&node_int_tx}};
        end else begin
            can_tx_pin <= node_int_tx;
            node_int_rx <= rx_sync_reg;
        end
    end
endmodule

// >>> core/mct_transfer_ctl.sv
`timescale 1ns/1ps
module mct_transfer_ctl (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] can_rx_pin,
    output logic [1:0] can_tx_pin,
    input wire logic [1:0] node_int_tx,
    output logic [1:0] node_int_rx,
    output logic [1:0] node_tx_obj_valid,
    output logic [1:0][4:0] node_tx_obj_idx,
    output logic [1:0] node_tx_obj_remote,
    output logic [1:0][63:0] node_tx_obj_data,
    input wire logic [1:0] node_tx_start,
    input wire logic [1:0][4:0] node_tx_start_idx,
    input wire logic [1:0] node_tx_done,
    input wire logic [1:0][4:0] node_tx_done_idx,
    input wire logic [1:0] node_rx_data,
    input wire logic [1:0] node_rx_remote,
    input wire logic [1:0][4:0] node_rx_idx,
    input wire logic [1:0][63:0] node_rx_payload
);
    localparam int N = mct_pkg::NUM_OBJ;

    // ****************************************
    // Object state
    // ****************************************
    logic [N-1:0] irq_pnd_reg;
    logic [N-1:0] valid_reg;
    logic [N-1:0] rmt_pnd_reg;
    logic [N-1:0] tx_request_reg;
    logic [N-1:0] newd_reg;
    logic [N-1:0] upd_reg;
    logic [N-1:0] lost_reg;
    logic [N-1:0] node_sel_reg;
    logic [N-1:0] dir_tx_reg;
    logic [N-1:0] stt_reg;
    logic [31:0] data_low_reg [N];
    logic [31:0] data_high_reg [N];
    logic btr_a_lbm_reg;
    logic btr_b_lbm_reg;
    logic lbm_active;

    // ****************************************
    // Bus slave state
    // ****************************************
    mct_pkg::mct_wr_state_t wr_state_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic [9:0] wr_addr_reg;
    logic [31:0] wr_data_reg;
    logic [3:0] wr_strb_reg;
    logic wr_fire;
    logic wr_obj_hit;
    logic [4:0] wr_obj;
    logic [3:0] wr_off;
    logic [31:0] wr_mask;

    // Byte strobes widened to a bit mask
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wr_mask[b*8 +: 8] = {8{wr_strb_reg[b]}};
        end
    end

    assign wr_fire = (wr_state_reg == mct_pkg::MCT_WR_COLLECT) && aw_held_reg && w_held_reg;
    assign wr_obj_hit = (wr_addr_reg[9] == 1'b0);
    assign wr_obj = wr_addr_reg[8:4];
    assign wr_off = {wr_addr_reg[3:2], 2'h0};
    assign lbm_active = btr_a_lbm_reg && btr_b_lbm_reg;

    // ****************************************
    // AXI4-Lite write channel
    // ****************************************
    // Address and data taken in either order; response after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_reg <= mct_pkg::MCT_WR_COLLECT;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            wr_addr_reg <= '0;
            wr_data_reg <= '0;
            wr_strb_reg <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= mct_pkg::RESP_OKAY;
        end else begin
            case (wr_state_reg)
                mct_pkg::MCT_WR_COLLECT: begin
                    s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready);
                    s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready);
                    if (s_axi_awvalid && s_axi_awready) begin
                        aw_held_reg <= 1'b1;
                        wr_addr_reg <= s_axi_awaddr;
                    end
                    if (s_axi_wvalid && s_axi_wready) begin
                        w_held_reg <= 1'b1;
                        wr_data_reg <= s_axi_wdata;
                        wr_strb_reg <= s_axi_wstrb;
                    end
                    if (wr_fire) begin
                        aw_held_reg <= 1'b0;
                        w_held_reg <= 1'b0;
                        s_axi_awready <= 1'b0;
                        s_axi_wready <= 1'b0;
                        s_axi_bvalid <= 1'b1;
                        // Unmapped space above the status word
                        if (!wr_obj_hit && wr_addr_reg[9:2] > mct_pkg::OFF_STATUS[9:2]) begin
                            s_axi_bresp <= mct_pkg::RESP_SLVERR;
                        end else begin
                            s_axi_bresp <= mct_pkg::RESP_OKAY;
                        end
                        wr_state_reg <= mct_pkg::MCT_WR_RESP;
                    end
                end
                mct_pkg::MCT_WR_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        s_axi_awready <= 1'b1;
                        s_axi_wready <= 1'b1;
                        wr_state_reg <= mct_pkg::MCT_WR_COLLECT;
                    end
                end
                default: begin
                    wr_state_reg <= mct_pkg::MCT_WR_COLLECT;
                end
            endcase
        end
    end

    // ****************************************
    // Control flags
    // ****************************************
    // Pair code: set, clear or leave alone
    function automatic logic pair_apply(input logic [1:0] code, input logic old);
        logic res;
        res = old;
        if (code == mct_pkg::CODE_SET) begin
            res = 1'b1;
        end else if (code == mct_pkg::CODE_CLR) begin
            res = 1'b0;
        end
        return res;
    endfunction

    // Hardware clears first, software next, hardware sets last: set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_pnd_reg <= '0;
            valid_reg <= '0;
            rmt_pnd_reg <= '0;
            tx_request_reg <= '0;
            newd_reg <= '0;
            upd_reg <= '0;
            lost_reg <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                logic t;
                logic r;
                logic nd;
                logic ls;
                logic u;
                logic v;
                logic ip;
                t = tx_request_reg[i];
                r = rmt_pnd_reg[i];
                nd = newd_reg[i];
                ls = lost_reg[i];
                u = upd_reg[i];
                v = valid_reg[i];
                ip = irq_pnd_reg[i];
                for (int k = 0; k < 2; k++) begin
                    if (node_tx_start[k] && node_tx_start_idx[k] == i[4:0] && stt_reg[i]) begin
                        t = 1'b0;
                    end
                    if (node_tx_done[k] && node_tx_done_idx[k] == i[4:0]) begin
                        t = 1'b0;
                        r = 1'b0;
                    end
                end
                if (wr_fire && wr_obj_hit && wr_obj == i[4:0] && wr_off == mct_pkg::OFF_CTRL) begin
                    if (wr_strb_reg[0]) begin
                        ip = pair_apply(wr_data_reg[mct_pkg::CTL_IRQ +: 2], ip);
                        v = pair_apply(wr_data_reg[mct_pkg::CTL_VALID +: 2], v);
                        r = pair_apply(wr_data_reg[mct_pkg::CTL_RMT +: 2], r);
                        t = pair_apply(wr_data_reg[mct_pkg::CTL_TX_REQUEST +: 2], t);
                    end
                    if (wr_strb_reg[1]) begin
                        nd = pair_apply(wr_data_reg[mct_pkg::CTL_NEWD +: 2], nd);
                        u = pair_apply(wr_data_reg[mct_pkg::CTL_UPD +: 2], u);
                        ls = pair_apply(wr_data_reg[mct_pkg::CTL_LOST +: 2], ls);
                    end
                end
                for (int k = 0; k < 2; k++) begin
                    if (node_rx_idx[k] == i[4:0] && valid_reg[i] && node_sel_reg[i] == k[0]) begin
                        if (node_rx_data[k]) begin
                            ls = ls | newd_reg[i];
                            nd = 1'b1;
                        end
                        if (node_rx_remote[k] && dir_tx_reg[i]) begin
                            t = 1'b1;
                            r = 1'b1;
                        end
                    end
                end
                tx_request_reg[i] <= t;
                rmt_pnd_reg[i] <= r;
                newd_reg[i] <= nd;
                lost_reg[i] <= ls;
                upd_reg[i] <= u;
                valid_reg[i] <= v;
                irq_pnd_reg[i] <= ip;
            end
        end
    end

    // ****************************************
    // Object configuration and node timing words
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            node_sel_reg <= '0;
            dir_tx_reg <= '0;
            stt_reg <= '0;
            btr_a_lbm_reg <= 1'b0;
            btr_b_lbm_reg <= 1'b0;
        end else if (wr_fire && wr_strb_reg[0]) begin
            if (wr_obj_hit && wr_off == mct_pkg::OFF_CFG) begin
                node_sel_reg[wr_obj] <= wr_data_reg[mct_pkg::CFG_NODE];
                dir_tx_reg[wr_obj] <= wr_data_reg[mct_pkg::CFG_DIR_TX];
                stt_reg[wr_obj] <= wr_data_reg[mct_pkg::CFG_STT];
            end
            if (wr_addr_reg == mct_pkg::OFF_BTR_A) begin
                btr_a_lbm_reg <= wr_data_reg[mct_pkg::BTR_LBM];
            end
            if (wr_addr_reg == mct_pkg::OFF_BTR_B) begin
                btr_b_lbm_reg <= wr_data_reg[mct_pkg::BTR_LBM];
            end
        end
    end

    // ****************************************
    // Message data storage
    // ****************************************
    // Reception overwrites software data in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < N; i++) begin
                data_low_reg[i] <= mct_pkg::RESET_WORD;
                data_high_reg[i] <= mct_pkg::RESET_WORD;
            end
        end else begin
            if (wr_fire && wr_obj_hit && wr_off == mct_pkg::OFF_DATA_LOW) begin
                data_low_reg[wr_obj] <= (data_low_reg[wr_obj] & ~wr_mask) | (wr_data_reg & wr_mask);
            end
            if (wr_fire && wr_obj_hit && wr_off == mct_pkg::OFF_DATA_HIGH) begin
                data_high_reg[wr_obj] <= (data_high_reg[wr_obj] & ~wr_mask)
                    | (wr_data_reg & wr_mask);
            end
            for (int k = 0; k < 2; k++) begin
                if (node_rx_data[k] && valid_reg[node_rx_idx[k]]
                        && node_sel_reg[node_rx_idx[k]] == k[0]) begin
                    data_low_reg[node_rx_idx[k]] <= node_rx_payload[k][31:0];
                    data_high_reg[node_rx_idx[k]] <= node_rx_payload[k][63:32];
                end
            end
        end
    end

    // ****************************************
    // AXI4-Lite read channel
    // ****************************************
    // One read at a time; data one cycle after address taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= mct_pkg::RESP_OKAY;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else if (s_axi_arvalid && s_axi_arready) begin
            logic [4:0] o;
            o = s_axi_araddr[8:4];
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mct_pkg::RESP_OKAY;
            s_axi_rdata <= '0;
            if (!s_axi_araddr[9]) begin
                case ({s_axi_araddr[3:2], 2'h0})
                    mct_pkg::OFF_CTRL: begin
                        s_axi_rdata[13:0] <= {enc(lost_reg[o]), enc(upd_reg[o]),
                            enc(newd_reg[o]), enc(tx_request_reg[o]), enc(rmt_pnd_reg[o]),
                            enc(valid_reg[o]), enc(irq_pnd_reg[o])};
                    end
                    mct_pkg::OFF_DATA_LOW: s_axi_rdata <= data_low_reg[o];
                    mct_pkg::OFF_DATA_HIGH: s_axi_rdata <= data_high_reg[o];
                    default: s_axi_rdata[2:0] <= {stt_reg[o], dir_tx_reg[o], node_sel_reg[o]};
                endcase
            end else if (s_axi_araddr == mct_pkg::OFF_BTR_A) begin
                s_axi_rdata[mct_pkg::BTR_LBM] <= btr_a_lbm_reg;
            end else if (s_axi_araddr == mct_pkg::OFF_BTR_B) begin
                s_axi_rdata[mct_pkg::BTR_LBM] <= btr_b_lbm_reg;
            end else if (s_axi_araddr == mct_pkg::OFF_STATUS) begin
                s_axi_rdata[2:0] <= {node_tx_obj_valid, lbm_active};
            end else begin
                s_axi_rresp <= mct_pkg::RESP_SLVERR;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // Flag shown as its pair code
    function automatic logic [1:0] enc(input logic f);
        return f ? mct_pkg::CODE_SET : mct_pkg::CODE_CLR;
    endfunction

    // ****************************************
    // Transmit selection per node
    // ****************************************
    mct_arb_if arb_if [2] ();

    for (genvar k = 0; k < 2; k++) begin : g_node
        // Receive objects send remote frames regardless of update flag
        assign arb_if[k].pending = valid_reg & tx_request_reg
            & ~(dir_tx_reg & upd_reg)
            & (k == 0 ? ~node_sel_reg : node_sel_reg);

        mct_tx_arbiter u_arb (
            .aclk(aclk),
            .aresetn(aresetn),
            .arb(arb_if[k])
        );

        // Offer re-checked against live state so a dropped request is withdrawn
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                node_tx_obj_valid[k] <= 1'b0;
                node_tx_obj_idx[k] <= '0;
                node_tx_obj_remote[k] <= 1'b0;
                node_tx_obj_data[k] <= '0;
            end else begin
                node_tx_obj_valid[k] <= arb_if[k].grant_valid
                    && arb_if[k].pending[arb_if[k].grant_idx];
                node_tx_obj_idx[k] <= arb_if[k].grant_idx;
                node_tx_obj_remote[k] <= !dir_tx_reg[arb_if[k].grant_idx];
                node_tx_obj_data[k] <= {data_high_reg[arb_if[k].grant_idx],
                    data_low_reg[arb_if[k].grant_idx]};
            end
        end
    end

    // ****************************************
    // Loop-back path
    // ****************************************
    mct_loopback u_loop (
        .aclk(aclk),
        .aresetn(aresetn),
        .lbm_active(lbm_active),
        .can_rx_pin(can_rx_pin),
        .node_int_tx(node_int_tx),
        .can_tx_pin(can_tx_pin),
        .node_int_rx(node_int_rx)
    );
endmodule

// >>> test/mct_props.sv
`timescale 1ns/1ps
module mct_props (
    input wire logic aclk,
    aresetn,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rvalid,
    s_axi_rready,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic [31:0] s_axi_wdata,
    s_axi_rdata,
    input wire logic [1:0] can_tx_pin,
    node_int_tx,
    node_int_rx
);
    logic [1:0] lb_reg;
    logic wr_hs;
    assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    // Select-bit shadow; needs aw and w together
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lb_reg <= 2'h0;
        end else if (wr_hs && s_axi_awaddr[9:3] == 7'h40) begin
            lb_reg[s_axi_awaddr[2]] <= s_axi_wdata[0];
        end
    end
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    chk_rst_idle: assert property (disable iff (1'b0)
        !aresetn |=> can_tx_pin == 2'h3 && !s_axi_bvalid && !s_axi_rvalid) else $error("reset");
    chk_b_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    chk_wr_answer: assert property (wr_hs |-> ##[1:2] s_axi_bvalid) else $error("no bvalid");
    chk_rd_answer: assert property (
        s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid) else $error("no rvalid");
    chk_aw_busy: assert property (
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("awready stayed");
    chk_lb_recessive: assert property (
        &lb_reg && $past(&lb_reg, 4) |-> can_tx_pin == 2'h3) else $error("tx not recessive");
    chk_lb_wired: assert property (
        &lb_reg && $past(&lb_reg, 4) |-> node_int_rx == {2{&$past(node_int_tx)}})
        else $error("wired rx wrong");
endmodule
bind mct_transfer_ctl mct_props u_props (.*);

// >>> test/mct_node_model.sv
`timescale 1ns/1ps
module mct_node_model (
    input wire logic aclk,
    aresetn,
    input wire logic [3:0] gap,
    input wire logic [1:0] node_tx_obj_valid,
    input wire logic [1:0][4:0] node_tx_obj_idx,
    output logic [1:0] node_tx_start,
    node_tx_done,
    node_int_tx,
    output logic [1:0][4:0] node_tx_start_idx,
    node_tx_done_idx
);
    logic [1:0][5:0] cnt_reg;
    // One engine per node; tail lets offer settle
    always_ff @(posedge aclk) begin
        for (int k = 0; k < 2; k++) begin
            node_tx_start[k] <= cnt_reg[k] == 6'h14;
            node_tx_done[k] <= cnt_reg[k] == 6'h6;
            node_int_tx[k] <= (cnt_reg[k] > 6'h6 && cnt_reg[k] < 6'h14) ? cnt_reg[k][0] : 1'b1;
            if (!aresetn) begin
                cnt_reg[k] <= 6'h0;
            end else if (cnt_reg[k] != 6'h0) begin
                cnt_reg[k] <= cnt_reg[k] - 6'h1;
            end else if (node_tx_obj_valid[k]) begin
                cnt_reg[k] <= 6'h15 + 6'(gap);
                node_tx_start_idx[k] <= node_tx_obj_idx[k];
                node_tx_done_idx[k] <= node_tx_obj_idx[k];
            end
        end
    end
endmodule

// >>> test/can_message_object_transfer_control_tb.sv
`timescale 1ns/1ps
module can_message_object_transfer_control_tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [9:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, gap;
    logic [1:0] s_axi_bresp, s_axi_rresp, can_rx_pin, can_tx_pin, node_int_tx, node_int_rx;
    logic [1:0] node_tx_obj_valid, node_tx_obj_remote, node_tx_start, node_tx_done;
    logic [1:0] node_rx_data, node_rx_remote;
    logic [1:0][4:0] node_tx_obj_idx, node_tx_start_idx, node_tx_done_idx, node_rx_idx;
    logic [1:0][63:0] node_tx_obj_data, node_rx_payload;
    logic [63:0] seen_data, pay;
    logic seen_rem;
    int seed = 1, bad_count = 0, comparisons = 0, cycles = 0;
    mct_transfer_ctl DUT (.*);
    mct_node_model u_nodes (.*);
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    // Pin noise, engine gaps, hang guard
    always @(posedge aclk) begin
        can_rx_pin <= 2'($random(seed));
        gap <= 4'($random(seed));
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            stop_test();
        end
    end
    function automatic logic [31:0] cw(input logic [6:0] f);
        cw = 32'h0;
        for (int i = 0; i < 7; i++) begin
            cw[2*i +: 2] = f[i] ? mct_pkg::CODE_SET : mct_pkg::CODE_CLR;
        end
    endfunction
    function automatic logic [31:0] wc(input int i, input logic s);
        wc = 32'(s ? mct_pkg::CODE_SET : mct_pkg::CODE_CLR) << (2 * i);
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // Each channel held until its own ready
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'h0, 32'(s_axi_bresp));
    endtask
    task automatic rc(input string n, input logic [9:0] a, input logic [31:0] e,
                      input logic [1:0] er = 2'h0);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(n, e, s_axi_rdata);
        chk(n, 32'(er), 32'(s_axi_rresp));
    endtask
    task automatic ev(input int k, input logic r, input logic [4:0] i, input logic [63:0] p);
        @(posedge aclk);
        node_rx_data[k] <= !r;
        node_rx_remote[k] <= r;
        node_rx_idx[k] <= i;
        node_rx_payload[k] <= p;
        @(posedge aclk);
        node_rx_data[k] <= 1'b0;
        node_rx_remote[k] <= 1'b0;
    endtask
    task automatic wt(input int k, input logic fin);
        while (!(fin ? node_tx_done[k] : node_tx_start[k])) @(posedge aclk);
        seen_data = node_tx_obj_data[k];
        seen_rem = node_tx_obj_remote[k];
    endtask
    task automatic stop_test();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {node_rx_data, node_rx_remote, node_rx_idx, node_rx_payload} = '0;
        s_axi_wstrb = 4'hf;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rc("ctl", 10'h090, cw(7'h00));
        rc("gap", 10'h20c, 32'h0, 2'h2);
        for (int i = 0; i < 4; i++) begin
            wr(10'h200, 32'(i % 2));
            wr(10'h204, 32'(i / 2));
            rc("lbm", 10'h208, 32'(i == 3));
        end
        // Transmit object, loop-back on
        pay = {$random(seed), $random(seed)};
        wr(10'h03c, 32'h2);
        wr(10'h030, wc(5, 1) | wc(3, 1));
        wr(10'h034, pay[31:0]);
        wr(10'h030, wc(4, 1) | wc(5, 0));
        rc("inval", 10'h208, 32'h1);
        wr(10'h030, wc(1, 1));
        wt(0, 0);
        chk("data", pay[31:0], seen_data[31:0]);
        wt(0, 1);
        rc("sent", 10'h030, cw(7'h12));
        wr(10'h04c, 32'h2);
        wr(10'h040, wc(1, 1) | wc(5, 1));
        ev(0, 1'b1, 5'h4, 64'h0);
        rc("held", 10'h040, cw(7'h2e));
        rc("hold", 10'h208, 32'h1);
        wr(10'h040, wc(5, 0));
        wt(0, 0);
        chk("kind", 32'h0, 32'(seen_rem));
        wt(0, 1);
        rc("ans", 10'h040, cw(7'h02));
        wr(10'h06c, 32'h7);
        wr(10'h060, wc(1, 1) | wc(3, 1));
        wt(1, 0);
        rc("stt", 10'h060, cw(7'h02));
        wt(1, 1);
        wr(10'h05c, 32'h1);
        wr(10'h050, wc(1, 1) | wc(3, 1));
        wt(1, 0);
        chk("rmt", 32'h1, 32'(seen_rem));
        wt(1, 1);
        // Unread frame overwritten
        ev(1, 1'b0, 5'h5, ~pay);
        ev(1, 1'b0, 5'h5, pay);
        rc("lost", 10'h050, cw(7'h52));
        rc("high", 10'h058, pay[63:32]);
        wr(10'h050, 32'hffff_ffff);
        wr(10'h050, wc(4, 0));
        rc("free", 10'h050, cw(7'h42));
        stop_test();
    end
endmodule
